// [bench/pmc_props.sv]
// Link checker between station and device ends
`timescale 1ns/1ns
`default_nettype none
`include "pmc_params.svh"
module pmc_props #(
  parameter logic [4:0] PHY_ADDR = `PMC_PHY_ADDR_DEF,
  parameter logic [4:0] EXT_ADDR = `PMC_EXT_ADDR_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mdc,
  input wire logic sta_mdio_out,
  input wire logic sta_mdio_oe_n,
  input wire logic dev_mdio_out,
  input wire logic dev_mdio_oe_n,
  input wire logic mdio
);
  logic mdc_r;
  logic oe_r;
  logic rd_r;
  logic [6:0] bitn_r;
  logic [4:0] ph_r;
  logic hit;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Station holds the line from bit 0, so its take-over marks a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdc_r <= 1'b0;
      oe_r <= 1'b1;
      rd_r <= 1'b0;
      bitn_r <= 7'h00;
      ph_r <= 5'h00;
    end else begin
      mdc_r <= mdc;
      oe_r <= sta_mdio_oe_n;
      if (oe_r && !sta_mdio_oe_n) bitn_r <= 7'h00;
      else if (mdc && !mdc_r && bitn_r != 7'h7F) bitn_r <= bitn_r + 7'h01;
      if (mdc && !mdc_r && bitn_r == 7'h22) rd_r <= mdio;
      if (mdc && !mdc_r && bitn_r >= 7'h24 && bitn_r <= 7'h28)
        ph_r <= {ph_r[3:0], mdio};
    end
  end
  always_comb hit = (ph_r == PHY_ADDR) || (ph_r == EXT_ADDR);
  sequence s_bit(int n);
    mdc && !mdc_r && bitn_r == n;
  endsequence
  property p_wta(int n, logic v);
    s_bit(n) ##0 !rd_r |-> mdio == v;
  endproperty
  AST_NO_CLASH: assert property (!dev_mdio_oe_n |-> sta_mdio_oe_n)
    else $error("both ends drive the data line");
  AST_DEV_QUIET: assert property (!dev_mdio_oe_n |->
    rd_r && bitn_r >= 46 && bitn_r <= 64)
    else $error("device drives outside read data");
  AST_PREAMBLE: assert property (mdc && !mdc_r && bitn_r < 32 |->
    mdio)
    else $error("preamble bit not one");
  AST_START0: assert property (s_bit(32) |-> !mdio)
    else $error("first start bit not zero");
  AST_START1: assert property (s_bit(33) |-> mdio)
    else $error("second start bit not one");
  AST_WR_TA1: assert property (p_wta(46, 1'b1))
    else $error("write turnaround first bit wrong");
  AST_WR_TA0: assert property (p_wta(47, 1'b0))
    else $error("write turnaround second bit wrong");
  AST_RD_TA0: assert property (s_bit(47) ##0 (rd_r && hit) |->
    !dev_mdio_oe_n && !mdio)
    else $error("read turnaround zero missing");
  AST_RD_DATA: assert property (mdc && !mdc_r && rd_r && hit &&
    bitn_r >= 48 && bitn_r <= 63 |-> !dev_mdio_oe_n)
    else $error("device not driving read data");
  AST_RELEASE: assert property (s_bit(63) |->
    ##[1:40] (sta_mdio_oe_n && dev_mdio_oe_n))
    else $error("line not released after frame");
  AST_MDC_HIGH: assert property ($rose(mdc) |-> mdc[*8])
    else $error("management clock high phase short");
  AST_STA_HOLD: assert property (mdc && !sta_mdio_oe_n |->
    $stable(sta_mdio_out))
    else $error("station data moved while clock high");
endmodule
`default_nettype wire

// [bench/port4_mii_config_and_smi_tb_top.sv]
// Bench joining station and device over the management link
`timescale 1ns/1ns
`default_nettype none
module port4_mii_config_and_smi_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [10:0] strap = 11'h000;
  logic an_speed = 1'b0;
  logic an_full = 1'b0;
  logic ee_we = 1'b0;
  logic [4:0] ee_addr = 5'h00;
  logic [15:0] ee_data = 16'h0000;
  wire [16:0] outs;
  wire [1:0] wan;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] r;
  logic e;
  logic [15:0] q;
  // Straps beside the expected decoded outputs, listed combos only
  logic [27:0] rows [6] = '{{11'h000, 17'h1FD80}, {11'h014, 17'h1F880},
    {11'h218, 17'h07B00}, {11'h411, 17'h0F846}, {11'h416, 17'h0F8DB},
    {11'h41E, 17'h0F9FB}};
  pmc_if lk ();
  pmc_sta i_pmc_sta (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mgmt(lk.sta));
  pmc_dev i_pmc_dev (.pclk(pclk), .presetn(presetn), .mgmt(lk.dev),
    .port4_extension_strap(strap[10]), .fiber_detect_strap(strap[9:5]),
    .port4_force_mode(strap[4]), .port4_speed_sel(strap[3]),
    .port4_duplex_sel(strap[2]), .lan_if_pause_enable(strap[1]),
    .lan_if_mac_role(strap[0]), .an_speed_100(an_speed),
    .an_full_duplex(an_full), .eeprom_we(ee_we), .eeprom_addr(ee_addr),
    .eeprom_data(ee_data), .five_port_switch(outs[16]),
    .auto_mdix_en(outs[15:11]), .port4_autoneg(outs[10]),
    .port4_fiber(outs[9]), .port4_speed_100(outs[8]), .port4_full(outs[7]),
    .lan_if_enable(outs[6]), .lan_if_speed_100(outs[5]),
    .lan_if_full(outs[4]), .lan_if_pause(outs[3]), .lan_if_mac(outs[2]),
    .port4_to_lan(outs[1]), .wan_if_enable(outs[0]),
    .wan_if_speed_100(wan[1]), .wan_if_full(wan[0]));
  pmc_props i_pmc_props (.pclk(pclk), .presetn(presetn), .mdc(lk.mdc),
    .sta_mdio_out(lk.sta_mdio_out), .sta_mdio_oe_n(lk.sta_mdio_oe_n),
    .dev_mdio_out(lk.dev_mdio_out), .dev_mdio_oe_n(lk.dev_mdio_oe_n),
    .mdio(lk.mdio));
  initial forever #2 pclk = ~pclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rq, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One frame, then poll until the station is idle again
  task automatic mgmt(input logic rd, input logic [4:0] ph,
    input logic [4:0] rg, input logic [15:0] d, output logic [15:0] rq);
    logic [31:0] v;
    logic er;
    apb(1'b1, 12'h000, {5'h00, rd, ph, rg, d}, v, er);
    do apb(1'b0, 12'h004, 32'h0, v, er); while (v[16] !== 1'b0);
    rq = v[15:0];
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    check({lk.mdc, lk.sta_mdio_oe_n, lk.dev_mdio_oe_n, pready}, 4'h6);
    presetn <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge pclk);
      strap <= rows[i][27:17];
      repeat (5) @(posedge pclk);
      check(outs, rows[i][16:0]);
    end
    $display("test straps done");
    an_full <= 1'b1;
    repeat (3) @(posedge pclk);
    check(wan, 2'b01);
    mgmt(1'b0, 5'h04, 5'h00, 16'h2000, q);
    repeat (5) @(posedge pclk);
    check(wan, 2'b10);
    mgmt(1'b1, 5'h04, 5'h00, 16'h0000, q);
    check(q, 16'h2000);
    $display("test basic override done");
    ee_we <= 1'b1;
    ee_addr <= 5'h12;
    ee_data <= 16'hA5C3;
    @(posedge pclk);
    ee_we <= 1'b0;
    mgmt(1'b1, 5'h1E, 5'h12, 16'h0000, q);
    check(q, 16'hA5C3);
    mgmt(1'b0, 5'h1E, 5'h13, 16'h5A3C, q);
    mgmt(1'b1, 5'h1E, 5'h13, 16'h0000, q);
    check(q, 16'h5A3C);
    apb(1'b0, 12'h000, 32'h0, r, e);
    check(r, 32'h07D3_0000);
    check(e, 1'b0);
    // Divider of zero is stored as one; restored before the next frame
    apb(1'b1, 12'h008, 32'h0, r, e);
    apb(1'b0, 12'h008, 32'h0, r, e);
    check(r, 32'h0000_0001);
    apb(1'b1, 12'h008, 32'h0000_0010, r, e);
    mgmt(1'b1, 5'h07, 5'h00, 16'h0000, q);
    check(q, 16'hFFFF);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    check(e, 1'b1);
    check(r, 32'h0);
    $display("test extended and refusals done");
    // Reset landing in mid-frame must free the line at once
    apb(1'b1, 12'h000, {5'h00, 1'b0, 5'h04, 5'h00, 16'h2100}, r, e);
    repeat (300) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({lk.mdc, lk.sta_mdio_oe_n, lk.dev_mdio_oe_n, pready}, 4'h6);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    check(wan, 2'b01);
    mgmt(1'b1, 5'h04, 5'h00, 16'h0000, q);
    check(q, 16'h3100);
    $display("test mid-frame reset done");
    results();
  end
endmodule
`default_nettype wire

// [include/pmc_if.sv]
// Management link between the station and the device
`timescale 1ns/1ns
`default_nettype none
interface pmc_if;
  logic mdc;
  logic sta_mdio_out;
  logic sta_mdio_oe_n;
  logic dev_mdio_out;
  logic dev_mdio_oe_n;
  logic mdio;

  // Pulled up when neither end drives
  assign mdio = !sta_mdio_oe_n ? sta_mdio_out :
                !dev_mdio_oe_n ? dev_mdio_out : 1'b1;

  modport sta (
    output mdc,
    output sta_mdio_out,
    output sta_mdio_oe_n,
    input mdio
  );

  modport dev (
    input mdc,
    input mdio,
    output dev_mdio_out,
    output dev_mdio_oe_n
  );
endinterface
`default_nettype wire

// [include/pmc_params.svh]
// Constants of the port-four setup and serial management block
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_CLK_PERIOD_NS 4
`define PMC_MDC_PERIOD_NS 125
`define PMC_MDC_HALF_CYC \
  ((`PMC_MDC_PERIOD_NS + 2 * `PMC_CLK_PERIOD_NS - 1) / \
   (2 * `PMC_CLK_PERIOD_NS))

`define PMC_PRE_LEN 6'h20
`define PMC_START 2'h1
`define PMC_OP_RD 2'h2
`define PMC_OP_WR 2'h1
`define PMC_TA_WR 2'h2
`define PMC_HDR_LAST 6'h0B
`define PMC_DATA_LAST 6'h0F
`define PMC_DATA_BITS 6'h10
`define PMC_FRAME_LAST 6'h3F
`define PMC_RD_REL_IDX 6'h2E
`define PMC_RD_DATA_IDX 6'h30

`define PMC_PHY_ADDR_DEF 5'h04
`define PMC_EXT_ADDR_DEF 5'h1E

`define PMC_BMCR_IDX 5'h00
`define PMC_BMCR_RST 16'h3100
`define PMC_BMCR_SPEED 13
`define PMC_BMCR_ANEN 12
`define PMC_BMCR_DUPLEX 8

`define PMC_CMD_OFS 12'h000
`define PMC_STATUS_OFS 12'h004
`define PMC_DIV_OFS 12'h008
`define PMC_CMD_RD_BIT 26
`define PMC_STATUS_BUSY_BIT 16
`define PMC_DIV_RST 16'h0010

`endif

// [include/pmc_pkg.sv]
// Types shared by the two ends of the management link
package pmc_pkg;

  typedef enum logic [2:0] {
    PMC_IDLE,
    PMC_STRT,
    PMC_HDR,
    PMC_TA,
    PMC_RD,
    PMC_WR
  } pmc_dev_state_type;

  typedef struct packed {
    pmc_dev_state_type st;
    logic mdc_q;
    logic [5:0] cnt;
    logic [11:0] hdr;
    logic [15:0] sh;
    logic mdio_out;
    logic mdio_oe_n;
    logic [31:0][15:0] basic;
    logic [31:0][15:0] ext;
    logic five_port;
    logic [4:0] mdix_en;
    logic p4_autoneg;
    logic p4_fiber;
    logic p4_speed_100;
    logic p4_full;
    logic lan_en;
    logic lan_speed_100;
    logic lan_full;
    logic lan_pause;
    logic lan_mac;
    logic p4_to_lan;
    logic wan_en;
    logic wan_speed_100;
    logic wan_full;
  } pmc_dev_state_type_s_type;

  typedef struct packed {
    logic busy;
    logic is_read;
    logic [26:0] cmd;
    logic [63:0] sh;
    logic [5:0] idx;
    logic [15:0] div;
    logic [15:0] div_cnt;
    logic [15:0] rdata;
    logic mdc;
    logic mdio_out;
    logic mdio_oe_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pmc_sta_state_type;

endpackage

// [logic/pmc_dev.sv]
// Device end: strap decode, port-four setup and management slave
`timescale 1ns/1ns
`default_nettype none
`include "pmc_params.svh"
module pmc_dev #(
  parameter logic [4:0] PHY_ADDR = `PMC_PHY_ADDR_DEF,
  parameter logic [4:0] EXT_ADDR = `PMC_EXT_ADDR_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  pmc_if.dev mgmt,
  input wire logic port4_extension_strap,
  input wire logic [4:0] fiber_detect_strap,
  input wire logic port4_force_mode,
  input wire logic port4_speed_sel,
  input wire logic port4_duplex_sel,
  input wire logic lan_if_pause_enable,
  input wire logic lan_if_mac_role,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic eeprom_we,
  input wire logic [4:0] eeprom_addr,
  input wire logic [15:0] eeprom_data,
  output logic five_port_switch,
  output logic [4:0] auto_mdix_en,
  output logic port4_autoneg,
  output logic port4_fiber,
  output logic port4_speed_100,
  output logic port4_full,
  output logic lan_if_enable,
  output logic lan_if_speed_100,
  output logic lan_if_full,
  output logic lan_if_pause,
  output logic lan_if_mac,
  output logic port4_to_lan,
  output logic wan_if_enable,
  output logic wan_if_speed_100,
  output logic wan_if_full
);
  pmc_pkg::pmc_dev_state_type_s_type r, n;
  logic [12:0] pins_s;
  logic s_mdc;
  logic s_mdio;
  logic s_ext;
  logic [4:0] s_fib;
  logic s_force;
  logic s_speed;
  logic s_duplex;
  logic s_pause;
  logic s_mac;

  // Straps and the link pins are all asynchronous to pclk
  pmc_sync #(
    .W(13)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({mgmt.mdc, mgmt.mdio, port4_extension_strap, fiber_detect_strap,
        port4_force_mode, port4_speed_sel, port4_duplex_sel,
        lan_if_pause_enable, lan_if_mac_role}),
    .q(pins_s)
  );

  assign {s_mdc, s_mdio, s_ext, s_fib, s_force, s_speed, s_duplex,
          s_pause, s_mac} = pins_s;

  always_comb begin
    logic rise;
    logic [4:0] phy;
    logic [4:0] rga;
    logic [15:0] wdat;
    logic [15:0] bmcr;
    rise = s_mdc & ~r.mdc_q;
    phy = r.hdr[9:5];
    rga = r.hdr[4:0];
    wdat = {r.sh[14:0], s_mdio};
    bmcr = r.basic[`PMC_BMCR_IDX];
    n = r;
    n.mdc_q = s_mdc;

    // Loader writes first so a link write in the same cycle wins
    if (eeprom_we) begin
      n.ext[eeprom_addr] = eeprom_data;
    end

    if (rise) begin
      case (r.st)
        pmc_pkg::PMC_IDLE: begin
          if (s_mdio) begin
            if (r.cnt != `PMC_PRE_LEN) begin
              n.cnt = r.cnt + 6'h01;
            end
          end else if (r.cnt == `PMC_PRE_LEN) begin
            n.st = pmc_pkg::PMC_STRT;
            n.cnt = 6'h00;
          end else begin
            n.cnt = 6'h00;
          end
        end
        pmc_pkg::PMC_STRT: begin
          // Second start bit must be one, else hunt again
          n.st = s_mdio ? pmc_pkg::PMC_HDR : pmc_pkg::PMC_IDLE;
          n.cnt = 6'h00;
        end
        pmc_pkg::PMC_HDR: begin
          n.hdr = {r.hdr[10:0], s_mdio};
          if (r.cnt == `PMC_HDR_LAST) begin
            n.st = pmc_pkg::PMC_TA;
            n.cnt = 6'h00;
          end else begin
            n.cnt = r.cnt + 6'h01;
          end
        end
        pmc_pkg::PMC_TA: begin
          if (r.hdr[11:10] == `PMC_OP_RD &&
              (phy == PHY_ADDR || phy == EXT_ADDR)) begin
            // Line was released by the station at the falling edge that opened this bit
            n.mdio_oe_n = 1'b0;
            n.mdio_out = 1'b0;
            n.sh = (phy == PHY_ADDR) ? r.basic[rga] : r.ext[rga];
            n.st = pmc_pkg::PMC_RD;
            n.cnt = 6'h00;
          end else if (r.hdr[11:10] == `PMC_OP_WR) begin
            if (r.cnt == 6'h01) begin
              n.st = pmc_pkg::PMC_WR;
              n.cnt = 6'h00;
            end else begin
              n.cnt = 6'h01;
            end
          end else begin
            // Read to a foreign address, or bad opcode: stay off the line
            n.st = pmc_pkg::PMC_IDLE;
            n.cnt = 6'h00;
          end
        end
        pmc_pkg::PMC_RD: begin
          if (r.cnt == `PMC_DATA_BITS) begin
            n.mdio_oe_n = 1'b1;
            n.mdio_out = 1'b1;
            n.st = pmc_pkg::PMC_IDLE;
            n.cnt = 6'h00;
          end else begin
            n.mdio_out = r.sh[15];
            n.sh = {r.sh[14:0], 1'b0};
            n.cnt = r.cnt + 6'h01;
          end
        end
        pmc_pkg::PMC_WR: begin
          n.sh = wdat;
          if (r.cnt == `PMC_DATA_LAST) begin
            if (phy == PHY_ADDR) begin
              n.basic[rga] = wdat;
            end else if (phy == EXT_ADDR) begin
              n.ext[rga] = wdat;
            end
            n.st = pmc_pkg::PMC_IDLE;
            n.cnt = 6'h00;
          end else begin
            n.cnt = r.cnt + 6'h01;
          end
        end
        default: begin
          n.st = pmc_pkg::PMC_IDLE;
          n.cnt = 6'h00;
        end
      endcase
    end

    // Plain switch only when no fiber and no extension strap
    n.five_port = ~s_ext & (s_fib == 5'h00);
    n.mdix_en = ~s_fib;

    // Fiber detect forces 100M fiber whatever the force strap says
    n.p4_fiber = s_fib[4];
    n.p4_autoneg = ~s_force & ~s_fib[4];
    n.p4_speed_100 = s_fib[4] | (s_force ? s_speed : 1'b1);
    n.p4_full = s_force ? s_duplex : 1'b1;

    // MAC role also takes speed and duplex from straps alone
    n.lan_en = s_ext;
    n.lan_speed_100 = s_ext & s_speed;
    n.lan_full = s_ext & s_duplex;
    n.lan_pause = s_ext & s_pause;
    n.lan_mac = s_ext & s_mac;
    n.p4_to_lan = s_ext;
    n.wan_en = s_ext & ~s_mac;

    // Control register override of the autoneg result
    if (bmcr[`PMC_BMCR_ANEN]) begin
      n.wan_speed_100 = an_speed_100;
      n.wan_full = an_full_duplex;
    end else begin
      n.wan_speed_100 = bmcr[`PMC_BMCR_SPEED];
      n.wan_full = bmcr[`PMC_BMCR_DUPLEX];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= pmc_pkg::PMC_IDLE;
      r.mdio_out <= 1'b1;
      r.mdio_oe_n <= 1'b1;
      r.basic[`PMC_BMCR_IDX] <= `PMC_BMCR_RST;
    end else begin
      r <= n;
    end
  end

  assign mgmt.dev_mdio_out = r.mdio_out;
  assign mgmt.dev_mdio_oe_n = r.mdio_oe_n;
  assign five_port_switch = r.five_port;
  assign auto_mdix_en = r.mdix_en;
  assign port4_autoneg = r.p4_autoneg;
  assign port4_fiber = r.p4_fiber;
  assign port4_speed_100 = r.p4_speed_100;
  assign port4_full = r.p4_full;
  assign lan_if_enable = r.lan_en;
  assign lan_if_speed_100 = r.lan_speed_100;
  assign lan_if_full = r.lan_full;
  assign lan_if_pause = r.lan_pause;
  assign lan_if_mac = r.lan_mac;
  assign port4_to_lan = r.p4_to_lan;
  assign wan_if_enable = r.wan_en;
  assign wan_if_speed_100 = r.wan_speed_100;
  assign wan_if_full = r.wan_full;
endmodule
`default_nettype wire

// [logic/pmc_sta.sv]
// Station end: APB registers driving management frames
`timescale 1ns/1ns
`default_nettype none
`include "pmc_params.svh"
module pmc_sta (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pmc_if.sta mgmt
);
  pmc_pkg::pmc_sta_state_type r, n;
  logic s_mdio;

  pmc_sync #(
    .W(1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(mgmt.mdio),
    .q(s_mdio)
  );

  always_comb begin
    logic rd;
    logic [63:0] frame;
    rd = pwdata[`PMC_CMD_RD_BIT];
    frame = {32'hFFFF_FFFF, `PMC_START,
             rd ? `PMC_OP_RD : `PMC_OP_WR, pwdata[25:16],
             rd ? 18'h3FFFF : {`PMC_TA_WR, pwdata[15:0]}};
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // One wait state so read data and pready come from flops
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      if (paddr == `PMC_CMD_OFS) begin
        n.prdata = {5'h00, r.cmd};
      end else if (paddr == `PMC_STATUS_OFS) begin
        n.prdata = {15'h0000, r.busy, r.rdata};
      end else if (paddr == `PMC_DIV_OFS) begin
        n.prdata = {16'h0000, r.div};
      end else begin
        n.pslverr = 1'b1;
      end
    end

    if (r.busy) begin
      if (r.div_cnt != 16'h0000) begin
        n.div_cnt = r.div_cnt - 16'h0001;
      end else begin
        n.div_cnt = r.div - 16'h0001;
        if (!r.mdc) begin
          n.mdc = 1'b1;
          if (r.is_read && r.idx >= `PMC_RD_DATA_IDX) begin
            n.rdata = {r.rdata[14:0], s_mdio};
          end
        end else begin
          // Bits change on the falling edge, half a period of margin
          n.mdc = 1'b0;
          if (r.idx == `PMC_FRAME_LAST) begin
            n.busy = 1'b0;
            n.mdio_oe_n = 1'b1;
            n.mdio_out = 1'b1;
          end else begin
            n.idx = r.idx + 6'h01;
            n.mdio_out = r.sh[63];
            n.sh = {r.sh[62:0], 1'b1};
            if (r.is_read && r.idx + 6'h01 >= `PMC_RD_REL_IDX) begin
              n.mdio_oe_n = 1'b1;
            end
          end
        end
      end
    end

    // Commands while busy are dropped; the frame on the wire is kept
    if (psel && penable && r.pready && pwrite) begin
      if (paddr == `PMC_CMD_OFS && !r.busy) begin
        n.cmd = pwdata[26:0];
        n.is_read = rd;
        n.busy = 1'b1;
        n.idx = 6'h00;
        n.mdc = 1'b0;
        n.div_cnt = r.div - 16'h0001;
        n.mdio_oe_n = 1'b0;
        n.mdio_out = frame[63];
        n.sh = {frame[62:0], 1'b1};
        n.rdata = 16'h0000;
      end else if (paddr == `PMC_DIV_OFS) begin
        n.div = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.div <= `PMC_DIV_RST;
      r.mdio_out <= 1'b1;
      r.mdio_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign mgmt.mdc = r.mdc;
  assign mgmt.sta_mdio_out = r.mdio_out;
  assign mgmt.sta_mdio_oe_n = r.mdio_oe_n;
endmodule
`default_nettype wire

// [logic/pmc_sync.sv]
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module pmc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire
